// ### verilog/ccp_params.svh
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH
// ****************************************
// Register map
// ****************************************
`define CCP_CLOCK_SETUP_ADDR 8'hF9
`define CCP_POWER_SETUP_ADDR 8'h87
`define CCP_CLOCK_SETUP_RST 8'h10
`define CCP_POWER_SETUP_RST 8'h00
// ****************************************
// Field positions
// ****************************************
`define CCP_DIVSEL_LSB 0
`define CCP_DIVSEL_MSB 2
`define CCP_AUTO_RESTORE_BIT 3
`define CCP_BKPT_EN_BIT 4
`define CCP_DOZE_BIT 0
`define CCP_DEEP_SLEEP_BIT 1
`define CCP_DIVSEL_FULL 3'h0
// ****************************************
// Timing
// ****************************************
`define CCP_RESTART_MACHINE_CYCLES 3
`define CCP_CLKS_PER_MACHINE_CYCLE 4
`endif

// ### verilog/ccp_pkg.sv
package ccp_pkg;
  typedef logic [2:0] ccp_divsel_t;
  typedef enum logic [1:0] {
    CCP_RUN,
    CCP_DOZE,
    CCP_DEEP_SLEEP,
    CCP_RESTART
  } ccp_mode_e;
endpackage

// ### verilog/ccp_divider.sv
`timescale 1ns/1ps
`include "ccp_params.svh"
// Free-running divider; emits a one-cycle tick per divided period
module ccp_divider #(
  parameter int WIDTH = 11
) (
  input wire logic core_clk_in, // Oscillator clock
  input wire logic srst_in, // Sync reset
  input wire logic ce_in, // Clock enable
  input wire ccp_pkg::ccp_divsel_t sel_in, // Divider select
  output logic tick_out // One per divided period
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] last_w;

  // ****************************************
  // Divisor decode
  // ****************************************
  function automatic logic [WIDTH-1:0] div_last(input ccp_pkg::ccp_divsel_t s);
    logic [WIDTH-1:0] r;
    r = '0;
    case (s)
      3'h0: r = WIDTH'(0);
      3'h1: r = WIDTH'(1);
      3'h2: r = WIDTH'(3);
      3'h3: r = WIDTH'(7);
      3'h4: r = WIDTH'(15);
      3'h5: r = WIDTH'(31);
      3'h6: r = WIDTH'(1023);
      default: r = WIDTH'(2047);
    endcase
    return r;
  endfunction

  assign last_w = div_last(sel_in);

  // New select applies at once; count restarts if beyond new limit
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      cnt_q <= '0;
    else if (ce_in)
    begin
      if (cnt_q >= last_w)
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + WIDTH'(1);
    end
  end

  assign tick_out = ce_in && (cnt_q >= last_w);
endmodule // ccp_divider

// ### verilog/ccp_clock_ctrl.sv
`timescale 1ns/1ps
`include "ccp_params.svh"
// Operation
// - Three-bit select divides core clock 1..2048
// - New divider select applies immediately
// - Core clock feeds core and watchdog
// - Core clock gated by deep sleep or doze
// - Peripheral clock undivided oscillator rate
// - Peripheral clock stops only in deep sleep
// - JTAG uses its own TCK
// - Debug reset works with core halted
// - Bit 4 enables breakpoint comparators
// - Auto restore forces select 000 on interrupt
// - Clock setup resets to 10h, reserved zero
// - Doze halts only the core and watchdog
// - Doze starts on write of doze bit
// - Core state frozen while clock gated
// - Enabled interrupt clears doze bit
// - Supervisor reset clears doze, restart after three
// - Supervisor resets active in doze
// - Port outputs hold during doze
// - Deep sleep bit1, doze bit0 at 87h
// - Deep sleep ends only by supervisor reset
module ccp_clock_ctrl #(
  parameter int DIV_WIDTH = 11
) (
  input wire logic core_clk_in, // Oscillator clock
  input wire logic srst_in, // Sync reset, active high
  input wire logic ce_in, // Clock enable
  input wire logic [7:0] sfr_addr_in, // Special register address
  input wire logic [7:0] sfr_wdata_in, // Write data
  input wire logic sfr_wr_in, // Write strobe
  input wire logic sfr_rd_in, // Read strobe
  input wire logic irq_in, // Enabled interrupt taken
  input wire logic sup_reset_in, // Supervisor reset pulse
  output logic [7:0] sfr_rdata_out, // Read data
  output logic sfr_rdata_valid_out, // Read data valid
  output logic core_clk_en_out, // Core and watchdog clock enable
  output logic io_unit_clk_en_out, // Peripheral clock enable
  output logic breakpoint_compare_enable_out, // Comparator enable
  output logic core_hold_out // Core held in restart
);
  localparam int RESTART_CYC = `CCP_RESTART_MACHINE_CYCLES * `CCP_CLKS_PER_MACHINE_CYCLE;
  logic [7:0] clock_setup_q;
  logic [1:0] power_setup_q;
  ccp_pkg::ccp_mode_e mode_q;
  logic [3:0] restart_cnt_q;
  logic div_tick;
  logic wr_clk;
  logic wr_pwr;

  // ****************************************
  // Register writes
  // ****************************************
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  assign wr_clk = ce_in && sfr_wr_in && addr_hit(sfr_addr_in, `CCP_CLOCK_SETUP_ADDR);
  assign wr_pwr = ce_in && sfr_wr_in && addr_hit(sfr_addr_in, `CCP_POWER_SETUP_ADDR);

  // Supervisor reset obeys the clock enable like any other state change
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      clock_setup_q <= `CCP_CLOCK_SETUP_RST;
    else if (ce_in)
    begin
      if (sup_reset_in)
        clock_setup_q <= `CCP_CLOCK_SETUP_RST;
      else
      begin
        if (wr_clk)
          clock_setup_q <= {3'h0, sfr_wdata_in[4:0]};
        if (irq_in && clock_setup_q[`CCP_AUTO_RESTORE_BIT])
          clock_setup_q[`CCP_DIVSEL_MSB:`CCP_DIVSEL_LSB] <= `CCP_DIVSEL_FULL;
      end
    end
  end

  // Power bits; deep sleep locks out writes until a supervisor reset
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      power_setup_q <= 2'(`CCP_POWER_SETUP_RST);
    else if (ce_in)
    begin
      if (sup_reset_in)
        power_setup_q <= 2'(`CCP_POWER_SETUP_RST);
      else
      begin
        if (wr_pwr && !power_setup_q[`CCP_DEEP_SLEEP_BIT])
          power_setup_q <= sfr_wdata_in[1:0];
        if (irq_in)
          power_setup_q[`CCP_DOZE_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Mode tracking
  // ****************************************
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      mode_q <= ccp_pkg::CCP_RUN;
      restart_cnt_q <= 4'h0;
    end
    else if (ce_in)
    begin
      if (sup_reset_in)
      begin
        mode_q <= ccp_pkg::CCP_RESTART;
        restart_cnt_q <= 4'(RESTART_CYC - 1);
      end
      else
      begin
        case (mode_q)
          ccp_pkg::CCP_RUN:
          begin
            if (power_setup_q[`CCP_DEEP_SLEEP_BIT])
              mode_q <= ccp_pkg::CCP_DEEP_SLEEP;
            else if (power_setup_q[`CCP_DOZE_BIT])
              mode_q <= ccp_pkg::CCP_DOZE;
          end
          ccp_pkg::CCP_DOZE:
          begin
            if (power_setup_q[`CCP_DEEP_SLEEP_BIT])
              mode_q <= ccp_pkg::CCP_DEEP_SLEEP;
            else if (!power_setup_q[`CCP_DOZE_BIT])
              mode_q <= ccp_pkg::CCP_RUN;
          end
          ccp_pkg::CCP_DEEP_SLEEP:
            mode_q <= ccp_pkg::CCP_DEEP_SLEEP;
          ccp_pkg::CCP_RESTART:
          begin
            if (restart_cnt_q == 4'h0)
              mode_q <= ccp_pkg::CCP_RUN;
            else
              restart_cnt_q <= restart_cnt_q - 4'h1;
          end
          default: mode_q <= ccp_pkg::CCP_RUN;
        endcase
      end
    end
  end

  // ****************************************
  // Core clock divider
  // ****************************************
  ccp_divider #(
    .WIDTH(DIV_WIDTH)
  ) ccp_divider_inst (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .sel_in(clock_setup_q[`CCP_DIVSEL_MSB:`CCP_DIVSEL_LSB]),
    .tick_out(div_tick)
  );

  // Enables are registered whole-cycle pulses, so no runt phases
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      core_clk_en_out <= 1'b0;
      io_unit_clk_en_out <= 1'b0;
    end
    else if (ce_in)
    begin
      core_clk_en_out <= div_tick && (power_setup_q == 2'h0)
        && !(wr_pwr && (sfr_wdata_in[1:0] != 2'h0));
      io_unit_clk_en_out <= !power_setup_q[`CCP_DEEP_SLEEP_BIT]
        && !(wr_pwr && sfr_wdata_in[`CCP_DEEP_SLEEP_BIT]);
    end
  end

  // JTAG clock and debug reset sit outside, arriving as sup_reset_in
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      breakpoint_compare_enable_out <= 1'b1;
      core_hold_out <= 1'b0;
      sfr_rdata_out <= 8'h00;
      sfr_rdata_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      breakpoint_compare_enable_out <= clock_setup_q[`CCP_BKPT_EN_BIT];
      core_hold_out <= sup_reset_in || (mode_q == ccp_pkg::CCP_RESTART);
      sfr_rdata_valid_out <= sfr_rd_in;
      if (addr_hit(sfr_addr_in, `CCP_CLOCK_SETUP_ADDR))
        sfr_rdata_out <= clock_setup_q;
      else if (addr_hit(sfr_addr_in, `CCP_POWER_SETUP_ADDR))
        sfr_rdata_out <= {6'h00, power_setup_q};
      else
        sfr_rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_reset_value;
    @(posedge core_clk_in) $fell(srst_in) |-> clock_setup_q == 8'h10;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value");

  property p_gate;
    @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && power_setup_q != 2'h0) |=> !core_clk_en_out;
  endproperty
  a_gate: assert property (p_gate) else $error("core clock not gated");

  property p_io_doze;
    @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && power_setup_q == 2'h1 && !wr_pwr) |=> io_unit_clk_en_out;
  endproperty
  a_io_doze: assert property (p_io_doze) else $error("peripheral clock stopped in doze");

  property p_restore;
    @(posedge core_clk_in) disable iff (srst_in || sup_reset_in)
      (ce_in && irq_in && clock_setup_q[3] && !wr_clk) |=> clock_setup_q[2:0] == 3'h0;
  endproperty
  a_restore: assert property (p_restore) else $error("auto restore failed");

  property p_irq_wake;
    @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && irq_in && !wr_pwr) |=> !power_setup_q[0];
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("doze not cleared");

  // Cycles since the last supervisor reset, for the restart check
  logic [3:0] since_sup_q;
  logic since_sup_vld_q;

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      since_sup_q <= 4'h0;
      since_sup_vld_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (sup_reset_in)
      begin
        since_sup_q <= 4'h0;
        since_sup_vld_q <= 1'b1;
      end
      else if (since_sup_vld_q)
      begin
        if (since_sup_q == 4'(RESTART_CYC))
          since_sup_vld_q <= 1'b0;
        else
          since_sup_q <= since_sup_q + 4'h1;
      end
    end
  end

  property p_restart;
    @(posedge core_clk_in) disable iff (srst_in)
      since_sup_vld_q |-> mode_q == ((since_sup_q == 4'(RESTART_CYC)) ?
        ccp_pkg::CCP_RUN : ccp_pkg::CCP_RESTART);
  endproperty
  a_restart: assert property (p_restart) else $error("restart length wrong");

  property p_reserved;
    @(posedge core_clk_in) disable iff (srst_in) clock_setup_q[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_deep;
    @(posedge core_clk_in) disable iff (srst_in || sup_reset_in)
      (mode_q == ccp_pkg::CCP_DEEP_SLEEP) |=> mode_q == ccp_pkg::CCP_DEEP_SLEEP;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep left without reset");

  property p_deep_bit;
    @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && power_setup_q[`CCP_DEEP_SLEEP_BIT] && !sup_reset_in) |=>
        power_setup_q[`CCP_DEEP_SLEEP_BIT];
  endproperty
  a_deep_bit: assert property (p_deep_bit) else $error("deep sleep bit lost");

  property p_io_deep;
    @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && power_setup_q[`CCP_DEEP_SLEEP_BIT]) |=> !io_unit_clk_en_out;
  endproperty
  a_io_deep: assert property (p_io_deep) else $error("peripheral clock runs in deep sleep");

  property p_hold;
    @(posedge core_clk_in) disable iff (srst_in)
      (ce_in && sup_reset_in) |=> core_hold_out;
  endproperty
  a_hold: assert property (p_hold) else $error("core not held after supervisor reset");

  property p_bkpt_reset;
    @(posedge core_clk_in) disable iff (srst_in)
      ((ce_in && sup_reset_in) ##1 ce_in) |=> breakpoint_compare_enable_out;
  endproperty
  a_bkpt_reset: assert property (p_bkpt_reset) else $error("comparators off after reset");

  property p_wr_clk;
    @(posedge core_clk_in) disable iff (srst_in)
      (wr_clk && !irq_in && !sup_reset_in) |=>
        clock_setup_q == {3'h0, $past(sfr_wdata_in[4:0])};
  endproperty
  a_wr_clk: assert property (p_wr_clk) else $error("clock setup write lost");

  c_doze: cover property (@(posedge core_clk_in) mode_q == ccp_pkg::CCP_DOZE);
  c_restore: cover property (@(posedge core_clk_in) ce_in && irq_in && clock_setup_q[3]);
  c_deep: cover property (@(posedge core_clk_in) mode_q == ccp_pkg::CCP_DEEP_SLEEP);
  c_restart: cover property (@(posedge core_clk_in) mode_q == ccp_pkg::CCP_RESTART);
endmodule // ccp_clock_ctrl

// ### dv/ccp_core_model.sv
`timescale 1ns/1ps
// Core side: counts clock enables and restart hold length
module ccp_core_model (
  input wire logic core_clk_in, // Oscillator clock
  input wire logic core_clk_en_in, // Core clock enable
  input wire logic io_unit_clk_en_in, // Peripheral clock enable
  input wire logic core_hold_in, // Restart hold
  output int core_ticks_out, // Core enable count
  output int io_ticks_out, // Peripheral enable count
  output int gap_out, // Cycles between last two core enables
  output int hold_len_out // Length of last hold
);
  int gap_q;
  int hold_q;
  always_ff @(posedge core_clk_in)
  begin
    gap_q <= core_clk_en_in ? 1 : gap_q + 1;
    if (core_clk_en_in)
    begin
      core_ticks_out <= core_ticks_out + 1;
      gap_out <= gap_q;
    end
    if (io_unit_clk_en_in)
    begin
      io_ticks_out <= io_ticks_out + 1;
    end
  end
  always_ff @(posedge core_clk_in)
  begin
    hold_q <= core_hold_in ? hold_q + 1 : 0;
    if (!core_hold_in && hold_q != 0)
    begin
      hold_len_out <= hold_q;
    end
  end
endmodule // ccp_core_model

// ### dv/tb_ccp_clock_ctrl.sv
`timescale 1ns/1ps
module tb_ccp_clock_ctrl;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic irq_in = 1'b0;
  logic sup_reset_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic sfr_rdata_valid_out, core_clk_en_out, io_unit_clk_en_out;
  logic breakpoint_compare_enable_out, core_hold_out;
  int bad_count = 0;
  int tests_run = 0;
  int ticks, io_ticks, gap, hold_len, n0, m0, i;
  localparam int DIVS[8] = '{1, 2, 4, 8, 16, 32, 1024, 2048};
  always #12.5 core_clk_in = ~core_clk_in;
  ccp_clock_ctrl ccp_clock_ctrl_inst (.core_clk_in, .srst_in, .ce_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .irq_in, .sup_reset_in, .sfr_rdata_out,
    .sfr_rdata_valid_out, .core_clk_en_out, .io_unit_clk_en_out,
    .breakpoint_compare_enable_out, .core_hold_out);
  ccp_core_model ccp_core_model_inst (.core_clk_in, .core_clk_en_in(core_clk_en_out),
    .io_unit_clk_en_in(io_unit_clk_en_out), .core_hold_in(core_hold_out),
    .core_ticks_out(ticks), .io_ticks_out(io_ticks), .gap_out(gap),
    .hold_len_out(hold_len));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge core_clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge core_clk_in);
    sfr_rd_in <= 1'b0;
    #1;
    chk("valid", 32'h1, 32'(sfr_rdata_valid_out));
    chk(what, 32'(exp), 32'(sfr_rdata_out));
  endtask
  task automatic irq();
    @(posedge core_clk_in);
    irq_in <= 1'b1;
    @(posedge core_clk_in);
    irq_in <= 1'b0;
  endtask
  task automatic sup();
    @(posedge core_clk_in);
    sup_reset_in <= 1'b1;
    @(posedge core_clk_in);
    sup_reset_in <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    srst_in <= 1'b0;
    wait_n(1);
    chk("bkpt", 32'h1, 32'(breakpoint_compare_enable_out));
    rd("clock_setup", 8'hF9, 8'h10);
    rd("power_setup", 8'h87, 8'h00);
    rd("unmapped", 8'h55, 8'h00);
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    wr(8'hF9, 8'h05);
    ce_in <= 1'b1;
    rd("ce_frozen", 8'hF9, 8'h10);
    for (i = 0; i < 8; i++)
    begin
      wr(8'hF9, 8'(i));
      wait_n(2 * DIVS[i] + 4);
      chk("gap", 32'(DIVS[i]), 32'(gap));
    end
    wr(8'hF9, 8'h00);
    wait_n(3);
    chk("gap_now", 32'h1, 32'(gap));
    wr(8'hF9, 8'hFF);
    rd("reserved", 8'hF9, 8'h1F);
    irq();
    rd("restore", 8'hF9, 8'h18);
    wr(8'hF9, 8'h06);
    irq();
    rd("no_restore", 8'hF9, 8'h06);
    wr(8'hF9, 8'h00);
    wait_n(2);
    chk("bkpt_off", 32'h0, 32'(breakpoint_compare_enable_out));
    wr(8'h87, 8'h01);
    wait_n(2);
    n0 = ticks;
    m0 = io_ticks;
    wait_n(20);
    chk("doze_core", 32'(n0), 32'(ticks));
    chk("doze_io", 32'(m0 + 20), 32'(io_ticks));
    rd("doze_bit", 8'h87, 8'h01);
    irq();
    rd("doze_clr", 8'h87, 8'h00);
    wait_n(4);
    chk("resume", 32'h1, 32'(ticks > n0));
    wr(8'h87, 8'h02);
    wait_n(2);
    n0 = ticks;
    m0 = io_ticks;
    wait_n(20);
    chk("sleep_core", 32'(n0), 32'(ticks));
    chk("sleep_io", 32'(m0), 32'(io_ticks));
    irq();
    rd("sleep_kept", 8'h87, 8'h02);
    sup();
    wait_n(20);
    chk("restart", 32'hD, 32'(hold_len));
    rd("sleep_clr", 8'h87, 8'h00);
    chk("io_back", 32'h1, 32'(io_unit_clk_en_out));
    wr(8'h87, 8'h01);
    sup();
    wait_n(20);
    rd("doze_sup", 8'h87, 8'h00);
    rd("setup_sup", 8'hF9, 8'h10);
    give_verdict();
  end
  initial
  begin
    repeat (30000) @(posedge core_clk_in);
    bad_count++;
    give_verdict();
  end
endmodule // tb_ccp_clock_ctrl
